// ---- ppm_map.svh ----
// Offsets, fields, resets and timing counts of the port block
`ifndef PPM_MAP_SVH
`define PPM_MAP_SVH
// Port-relative register offsets
`define PPM_OFF_DATA 11'h000
`define PPM_OFF_STATUS 11'h001
`define PPM_OFF_CONTROL 11'h002
`define PPM_OFF_EPP_ADDR 11'h003
`define PPM_OFF_EPP_DATA 11'h004
`define PPM_OFF_FIFO 11'h400
`define PPM_OFF_EXT_CTRL 11'h402
`define PPM_OFF_IND_INDEX 11'h403
`define PPM_OFF_IND_DATA 11'h404
// Second-level index of the secondary port control register
`define PPM_IDX_SEC_CTRL 8'h02
// Configuration indices
`define PPM_CFG_PORT_MODE 8'hf0
`define PPM_CFG_IRQ_SEL 8'h70
`define PPM_CFG_DMA_SEL 8'h74
// Field positions
`define PPM_MODE_HI 7
`define PPM_MODE_LO 5
`define PPM_CFG_DYN_BIT 4
`define PPM_SEC_COMPAT_BIT 7
`define PPM_SEC_EPP19_BIT 4
`define PPM_FER_PORT_EN_BIT 4
`define PPM_CTR_DIR_BIT 5
`define PPM_CTR_IRQ_EN_BIT 4
`define PPM_ECR_SERVICE_BIT 2
`define PPM_ECR_DMA_EN_BIT 3
// Reset values: dynamic configuration with extended control in ECP
`define PPM_CFG_RESET 8'hf0
`define PPM_ECR_RESET 8'h61
`define PPM_SEC_RESET 8'h00
`define PPM_CTR_RESET 8'h04
`define PPM_IRQ_RESET 4'h7
`define PPM_DMA_RESET 2'h0
// FIFO depth and service threshold
`define PPM_FIFO_DEPTH 16
`define PPM_FIFO_AW 4
`define PPM_FIFO_THRESH 5'h08
// Timing: clock period, strobe width and EPP time-out
`define PPM_CLK_NS 4
`define PPM_STROBE_NS 500
`define PPM_STROBE_CYC ((`PPM_STROBE_NS + `PPM_CLK_NS - 1) / `PPM_CLK_NS)
`define PPM_EPP_TMO_NS 10000
`define PPM_EPP_TMO_CYC (`PPM_EPP_TMO_NS / `PPM_CLK_NS)
`endif

// ---- ppm_pkg.sv ----
// Types of the parallel port mode block: mode select and handshake states
`default_nettype none
package ppm_pkg;
  typedef enum logic [5:0] {
    MODE_SPP_COMPAT = 6'b00_0001,
    MODE_SPP_EXT = 6'b00_0010,
    MODE_FIFO_OUT = 6'b00_0100,
    MODE_EPP17 = 6'b00_1000,
    MODE_EPP19 = 6'b01_0000,
    MODE_ECP = 6'b10_0000
  } ppm_mode_t;
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_SETUP = 4'b0010,
    HS_PULSE = 4'b0100,
    HS_WAIT = 4'b1000
  } ppm_hs_t;
endpackage
`default_nettype wire

// ---- ppm_fifo.sv ----
// Sixteen-entry byte FIFO with registered output
`default_nettype none
`include "ppm_map.svh"
module ppm_fifo (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic rd_ready,
  output logic [4:0] level
);
  logic [7:0] mem [0:`PPM_FIFO_DEPTH-1];
  logic [`PPM_FIFO_AW-1:0] wp_r;
  logic [`PPM_FIFO_AW-1:0] rp_r;
  logic [4:0] cnt_r;
  logic out_v_r;
  logic [7:0] out_d_r;
  logic push;
  logic load;

  // Accept while not full; refill output stage when free
  assign wr_ready = (cnt_r != 5'h10);
  assign push = wr_valid & wr_ready;
  assign load = (cnt_r != 5'h00) & (~out_v_r | rd_ready);
  assign rd_valid = out_v_r;
  assign rd_data = out_d_r;
  assign level = cnt_r;

  // Storage array needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= wr_data;
    end
  end

  // Pointers and count; flush empties everything at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= 5'h00;
    end else if (flush) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= 5'h00;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (load) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= 5'(cnt_r + {4'h0, push} - {4'h0, load});
    end
  end

  // Read data comes out of a register so the drain side sees clean timing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_v_r <= 1'b0;
      out_d_r <= 8'h00;
    end else if (flush) begin
      out_v_r <= 1'b0;
    end else begin
      if (load) begin
        out_d_r <= mem[rp_r];
      end
      out_v_r <= load | (out_v_r & ~rd_ready);
    end
  end
endmodule
`default_nettype wire

// ---- ppm_port.sv ----
// Parallel port mode selection, configuration registers and pin handshake
//
// Functional notes
// - ECP mode after reset, no software needed
// - Static mode from configuration bits 7-5
// - Static decode: compat, extended, EPP 1.7, 1.9
// - Dynamic only when bit4 set, bits 110/111
// - Dynamic mode from extended control and secondary
// - Secondary registers reached through index and data
// - Dynamic decode: compat, extended, FIFO, ECP, EPP
// - Secondary bit 7 qualifies compatibility behaviour
// - Port inactive until function enable bit 4
// - Interrupt routable, DMA to three channels
// - Reset floats strobes and interrupt, init low
// - Compatible mode outputs data, software paced
// - FIFO mode: buffered output, hardware handshake
// - Extended mode transfers bytes both directions
// - ECP: bidirectional 16-level FIFO, threshold, DMA
// - EPP 1.9 waits handshake, 1.7 fixed timing
`default_nettype none
`include "ppm_map.svh"
module ppm_port (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic [10:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  output logic [7:0] BUS_RDATA,
  input wire logic CFG_WR,
  input wire logic [7:0] CFG_INDEX,
  input wire logic [7:0] CFG_WDATA,
  output logic [7:0] CFG_RDATA,
  input wire logic FUNC_ENABLE_ONE_WR,
  input wire logic [2:0] DACK_N,
  output logic [2:0] DRQ,
  output logic [15:0] IRQ_O,
  output logic [15:0] IRQ_OE,
  input wire logic [7:0] PD_I,
  output logic [7:0] PD_O,
  output logic PD_OE,
  output logic DATA_STROBE_LINE_N_O,
  output logic DATA_STROBE_LINE_N_OE,
  output logic AUTO_FEED_LINE_N_O,
  output logic AUTO_FEED_LINE_N_OE,
  output logic SELECT_IN_LINE_N_O,
  output logic SELECT_IN_LINE_N_OE,
  output logic PRINTER_INIT_N_O,
  input wire logic ACK_N_I,
  input wire logic BUSY_I,
  input wire logic PAPER_END_I,
  input wire logic SELECT_I,
  input wire logic ERROR_N_I,
  output logic [5:0] MODE_SEL,
  output logic COMPAT_QUAL
);
  localparam logic [11:0] STROBE_CYC = 12'(`PPM_STROBE_CYC);
  localparam logic [11:0] TMO_CYC = 12'(`PPM_EPP_TMO_CYC);

  logic [7:0] cfg_r, ecr_r, sec_r, ctr_r, data_r, index_r, fer_r;
  logic [3:0] irq_sel_r;
  logic [1:0] dma_sel_r;
  ppm_pkg::ppm_mode_t mode_r, mode_nxt;
  ppm_pkg::ppm_hs_t hs_r;
  logic [11:0] hs_cnt_r;
  logic [12:0] pin_s1_r, pin_s2_r;
  logic ack_d_r, irq_flag_r, tmo_r, epp_addr_r;
  logic [7:0] epp_byte_r;
  logic epp_req_r;
  logic [7:0] pd_s, status;
  logic ack_s, busy_s, en, dyn, fwd, fifo_mode;
  logic ack_rise, ack_fall, dma_wr;
  logic wr_data, wr_fifo, rd_fifo, wr_ecr, wr_ind, wr_ctr;
  logic f_wr_valid, f_wr_ready, f_rd_valid, f_rd_ready;
  logic [7:0] f_wr_data, f_rd_data;
  logic [4:0] f_level;
  logic hs_take;

  // Two-flop synchronisers on all pin inputs
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_s1_r <= 13'h1fff;
      pin_s2_r <= 13'h1fff;
    end else begin
      pin_s1_r <= {ACK_N_I, BUSY_I, PAPER_END_I, SELECT_I, ERROR_N_I, PD_I};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign pd_s = pin_s2_r[7:0];
  assign ack_s = pin_s2_r[12];
  assign busy_s = pin_s2_r[11];

  // Edge detect reads the second stage only
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_d_r <= 1'b1;
    end else begin
      ack_d_r <= ack_s;
    end
  end
  assign ack_rise = ack_s & ~ack_d_r;
  assign ack_fall = ~ack_s & ack_d_r;

  assign en = fer_r[`PPM_FER_PORT_EN_BIT];
  assign dyn = cfg_r[`PPM_CFG_DYN_BIT] && cfg_r[7:6] == 2'b11;
  assign fwd = ~ctr_r[`PPM_CTR_DIR_BIT];
  assign fifo_mode = (mode_r == ppm_pkg::MODE_FIFO_OUT) || (mode_r == ppm_pkg::MODE_ECP);

  // Bus decodes; nothing in the port answers while it is disabled
  assign wr_data = en & BUS_WR & (BUS_ADDR == `PPM_OFF_DATA);
  assign wr_ctr = en & BUS_WR & (BUS_ADDR == `PPM_OFF_CONTROL);
  assign wr_ecr = en & BUS_WR & (BUS_ADDR == `PPM_OFF_EXT_CTRL);
  assign wr_ind = en & BUS_WR & (BUS_ADDR == `PPM_OFF_IND_DATA);
  assign dma_wr = en & BUS_WR & ~DACK_N[dma_sel_r];
  assign wr_fifo = (en & BUS_WR & (BUS_ADDR == `PPM_OFF_FIFO)) | dma_wr;
  assign rd_fifo = en & BUS_RD & (BUS_ADDR == `PPM_OFF_FIFO);

  // Configuration side: mode byte, interrupt and DMA routing, function enable
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_r <= `PPM_CFG_RESET;
      irq_sel_r <= `PPM_IRQ_RESET;
      dma_sel_r <= `PPM_DMA_RESET;
      fer_r <= 8'h00;
    end else begin
      if (CFG_WR && CFG_INDEX == `PPM_CFG_PORT_MODE) begin
        cfg_r <= CFG_WDATA;
      end
      // Lines 0, 2 and 13 are not routable; such writes are dropped
      if (CFG_WR && CFG_INDEX == `PPM_CFG_IRQ_SEL && CFG_WDATA[3:0] != 4'h0 &&
          CFG_WDATA[3:0] != 4'h2 && CFG_WDATA[3:0] != 4'hd) begin
        irq_sel_r <= CFG_WDATA[3:0];
      end
      if (CFG_WR && CFG_INDEX == `PPM_CFG_DMA_SEL && CFG_WDATA[1:0] != 2'h3) begin
        dma_sel_r <= CFG_WDATA[1:0];
      end
      if (FUNC_ENABLE_ONE_WR) begin
        fer_r <= CFG_WDATA;
      end
    end
  end

  // Configuration read-back, registered
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      CFG_RDATA <= 8'h00;
    end else begin
      case (CFG_INDEX)
        `PPM_CFG_PORT_MODE: CFG_RDATA <= cfg_r;
        `PPM_CFG_IRQ_SEL: CFG_RDATA <= {4'h0, irq_sel_r};
        `PPM_CFG_DMA_SEL: CFG_RDATA <= {6'h00, dma_sel_r};
        default: CFG_RDATA <= 8'h00;
      endcase
    end
  end

  // Port registers: data latch, control, extended control, index, secondary
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      data_r <= 8'h00;
      ctr_r <= `PPM_CTR_RESET;
      ecr_r <= `PPM_ECR_RESET;
      index_r <= 8'h00;
      sec_r <= `PPM_SEC_RESET;
    end else begin
      if (wr_data) begin
        data_r <= BUS_WDATA;
      end
      if (wr_ctr) begin
        ctr_r <= BUS_WDATA;
      end
      if (wr_ecr) begin
        ecr_r <= BUS_WDATA;
      end
      if (en && BUS_WR && BUS_ADDR == `PPM_OFF_IND_INDEX) begin
        index_r <= BUS_WDATA;
      end
      // Revision bit only moves while the configuration unlock bit is set
      if (wr_ind && index_r == `PPM_IDX_SEC_CTRL) begin
        sec_r <= BUS_WDATA;
        if (!cfg_r[`PPM_CFG_DYN_BIT]) begin
          sec_r[`PPM_SEC_EPP19_BIT] <= sec_r[`PPM_SEC_EPP19_BIT];
        end
      end
    end
  end

  // Mode decode: static byte, or extended control once unlocked
  always_comb begin
    mode_nxt = mode_r;
    if (!dyn) begin
      case (cfg_r[`PPM_MODE_HI:`PPM_MODE_LO])
        3'b000: mode_nxt = ppm_pkg::MODE_SPP_COMPAT;
        3'b001: mode_nxt = ppm_pkg::MODE_SPP_EXT;
        3'b010: mode_nxt = ppm_pkg::MODE_EPP17;
        3'b011: mode_nxt = ppm_pkg::MODE_EPP19;
        default: mode_nxt = mode_r;
      endcase
    end else begin
      case (ecr_r[`PPM_MODE_HI:`PPM_MODE_LO])
        3'b000: mode_nxt = ppm_pkg::MODE_SPP_COMPAT;
        3'b001: mode_nxt = ppm_pkg::MODE_SPP_EXT;
        3'b010: mode_nxt = ppm_pkg::MODE_FIFO_OUT;
        3'b011: mode_nxt = ppm_pkg::MODE_ECP;
        3'b100: mode_nxt = sec_r[`PPM_SEC_EPP19_BIT] ? ppm_pkg::MODE_EPP19 : ppm_pkg::MODE_EPP17;
        default: mode_nxt = mode_r;
      endcase
    end
  end

  // Registered one-hot select feeds the mode-specific paths; COMPAT_QUAL is taken from mode_nxt
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_r <= ppm_pkg::MODE_ECP;
      COMPAT_QUAL <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      COMPAT_QUAL <= dyn & (mode_nxt != ppm_pkg::MODE_ECP) & sec_r[`PPM_SEC_COMPAT_BIT];
    end
  end
  assign MODE_SEL = mode_r;

  // FIFO feed: host or DMA forward, ack-captured bytes in reverse
  assign f_wr_valid = fifo_mode & (fwd ? wr_fifo : (mode_r == ppm_pkg::MODE_ECP) & ack_fall);
  assign f_wr_data = fwd ? BUS_WDATA : pd_s;
  assign f_rd_ready = fwd ? hs_take : rd_fifo;

  ppm_fifo u_fifo (
    .clk(CLOCK),
    .rst_n(ARST_N),
    .flush(~fifo_mode),
    .wr_valid(f_wr_valid),
    .wr_data(f_wr_data),
    .wr_ready(f_wr_ready),
    .rd_valid(f_rd_valid),
    .rd_data(f_rd_data),
    .rd_ready(f_rd_ready),
    .level(f_level)
  );

  // EPP strobes at offsets 3 and 4 queue one transfer for the handshake
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      epp_req_r <= 1'b0;
      epp_addr_r <= 1'b0;
      epp_byte_r <= 8'h00;
    end else if (en && BUS_WR && (BUS_ADDR == `PPM_OFF_EPP_ADDR || BUS_ADDR == `PPM_OFF_EPP_DATA) &&
                 (mode_r == ppm_pkg::MODE_EPP17 || mode_r == ppm_pkg::MODE_EPP19)) begin
      epp_req_r <= 1'b1;
      epp_addr_r <= (BUS_ADDR == `PPM_OFF_EPP_ADDR);
      epp_byte_r <= BUS_WDATA;
    end else if (hs_r == ppm_pkg::HS_SETUP) begin
      epp_req_r <= 1'b0;
    end
  end

  // Hardware handshake: busy stalls the drain, so the FIFO really fills
  assign hs_take = (hs_r == ppm_pkg::HS_IDLE) & f_rd_valid & ~busy_s & en &
                   (mode_r == ppm_pkg::MODE_FIFO_OUT || (mode_r == ppm_pkg::MODE_ECP && fwd));
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      hs_r <= ppm_pkg::HS_IDLE;
      hs_cnt_r <= 12'h000;
      tmo_r <= 1'b0;
    end else begin
      // Status read clears the time-out first, so a new time-out wins
      if (en && BUS_RD && BUS_ADDR == `PPM_OFF_STATUS) begin
        tmo_r <= 1'b0;
      end
      case (hs_r)
        ppm_pkg::HS_IDLE: begin
          hs_cnt_r <= 12'h000;
          if (hs_take || epp_req_r) begin
            hs_r <= ppm_pkg::HS_SETUP;
          end
        end
        ppm_pkg::HS_SETUP: begin
          hs_r <= ppm_pkg::HS_PULSE;
        end
        ppm_pkg::HS_PULSE: begin
          hs_cnt_r <= hs_cnt_r + 12'h001;
          if (mode_r == ppm_pkg::MODE_EPP19) begin
            // Full interlock: wait for the peripheral, give up after the time-out
            if (busy_s) begin
              hs_r <= ppm_pkg::HS_WAIT;
            end else if (hs_cnt_r == TMO_CYC - 12'h001) begin
              tmo_r <= 1'b1;
              hs_r <= ppm_pkg::HS_IDLE;
            end
          end else if (hs_cnt_r == STROBE_CYC - 12'h001) begin
            hs_r <= ppm_pkg::HS_WAIT;
          end
        end
        ppm_pkg::HS_WAIT: begin
          // Older EPP revision does not wait for the peripheral here
          if (mode_r == ppm_pkg::MODE_EPP17 || (mode_r == ppm_pkg::MODE_EPP19 ? ~busy_s : 1'b1)) begin
            hs_r <= ppm_pkg::HS_IDLE;
          end
        end
        default: hs_r <= ppm_pkg::HS_IDLE;
      endcase
    end
  end

  // Data and control pins; only init is driven, held low, until the port is enabled
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      PD_O <= 8'h00;
      PD_OE <= 1'b0;
      DATA_STROBE_LINE_N_O <= 1'b1;
      DATA_STROBE_LINE_N_OE <= 1'b0;
      AUTO_FEED_LINE_N_O <= 1'b1;
      AUTO_FEED_LINE_N_OE <= 1'b0;
      SELECT_IN_LINE_N_O <= 1'b1;
      SELECT_IN_LINE_N_OE <= 1'b0;
      PRINTER_INIT_N_O <= 1'b0;
    end else begin
      PD_OE <= en & (fwd | (mode_r == ppm_pkg::MODE_SPP_COMPAT));
      DATA_STROBE_LINE_N_OE <= en;
      AUTO_FEED_LINE_N_OE <= en;
      SELECT_IN_LINE_N_OE <= en;
      PRINTER_INIT_N_O <= en & ctr_r[2];
      if (hs_take) begin
        PD_O <= f_rd_data;
      end else if (hs_r == ppm_pkg::HS_IDLE && epp_req_r) begin
        PD_O <= epp_byte_r;
      end else if (!fifo_mode && hs_r == ppm_pkg::HS_IDLE) begin
        PD_O <= data_r;
      end
      if (fifo_mode || mode_r == ppm_pkg::MODE_EPP17 || mode_r == ppm_pkg::MODE_EPP19) begin
        // Hardware owns the strobes in FIFO, ECP and EPP
        DATA_STROBE_LINE_N_O <= ~(fifo_mode & hs_r == ppm_pkg::HS_PULSE);
        AUTO_FEED_LINE_N_O <= ~(~fifo_mode & ~epp_addr_r & hs_r == ppm_pkg::HS_PULSE);
        SELECT_IN_LINE_N_O <= ~(~fifo_mode & epp_addr_r & hs_r == ppm_pkg::HS_PULSE);
      end else begin
        DATA_STROBE_LINE_N_O <= ~ctr_r[0];
        AUTO_FEED_LINE_N_O <= ~ctr_r[1];
        SELECT_IN_LINE_N_O <= ~ctr_r[3];
      end
    end
  end

  // Status byte: timeout, interrupt flag and synchronised printer lines
  assign status = {~busy_s, ack_s, pin_s2_r[10], pin_s2_r[9], pin_s2_r[8], ~irq_flag_r, 1'b1,
                   (mode_r == ppm_pkg::MODE_EPP17 || mode_r == ppm_pkg::MODE_EPP19) ? tmo_r : 1'b1};

  // Acknowledge flag, sticky until status read; set wins
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_flag_r <= 1'b0;
    end else if (ack_rise && ctr_r[`PPM_CTR_IRQ_EN_BIT]) begin
      irq_flag_r <= 1'b1;
    end else if (en && BUS_RD && BUS_ADDR == `PPM_OFF_STATUS) begin
      irq_flag_r <= 1'b0;
    end
  end

  // Register read mux, registered
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUS_RDATA <= 8'h00;
    end else if (!en) begin
      BUS_RDATA <= 8'h00;
    end else begin
      case (BUS_ADDR)
        `PPM_OFF_DATA: BUS_RDATA <= (mode_r == ppm_pkg::MODE_SPP_EXT && !fwd) ? pd_s : data_r;
        `PPM_OFF_STATUS: BUS_RDATA <= status;
        `PPM_OFF_CONTROL: BUS_RDATA <= ctr_r;
        `PPM_OFF_FIFO: BUS_RDATA <= f_rd_data;
        `PPM_OFF_EXT_CTRL: BUS_RDATA <= {ecr_r[7:2], ~f_wr_ready, ~f_rd_valid & (f_level == 5'h00)};
        `PPM_OFF_IND_INDEX: BUS_RDATA <= index_r;
        `PPM_OFF_IND_DATA: BUS_RDATA <= (index_r == `PPM_IDX_SEC_CTRL) ? sec_r : 8'h00;
        default: BUS_RDATA <= 8'h00;
      endcase
    end
  end

  // DMA request on the selected channel while FIFO has room
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      DRQ <= 3'b000;
    end else begin
      DRQ <= 3'b000;
      DRQ[dma_sel_r] <= en & fifo_mode & fwd & ecr_r[`PPM_ECR_DMA_EN_BIT] & f_wr_ready;
    end
  end

  // One interrupt line driven, the rest floated
  genvar g;
  for (g = 0; g < 16; g++) begin : g_irq
    always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
        IRQ_O[g] <= 1'b0;
        IRQ_OE[g] <= 1'b0;
      end else begin
        IRQ_OE[g] <= en & (irq_sel_r == 4'(g)) & ((mode_r == ppm_pkg::MODE_ECP) | ctr_r[`PPM_CTR_IRQ_EN_BIT]);
        IRQ_O[g] <= (mode_r == ppm_pkg::MODE_ECP) ?
                    (~ecr_r[`PPM_ECR_SERVICE_BIT] & (fwd ? f_level <= `PPM_FIFO_THRESH
                                                         : f_level >= `PPM_FIFO_THRESH)) : irq_flag_r;
      end
    end
  end
endmodule
`default_nettype wire

// ---- ppm_port_sva.sv ----
// Assertions of the parallel port mode block
`default_nettype none
module ppm_port_chk (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic [10:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic [7:0] BUS_RDATA,
  input wire logic CFG_WR,
  input wire logic [7:0] CFG_INDEX,
  input wire logic [7:0] CFG_WDATA,
  input wire logic FUNC_ENABLE_ONE_WR,
  input wire logic [2:0] DRQ,
  input wire logic [15:0] IRQ_OE,
  input wire logic DATA_STROBE_LINE_N_O,
  input wire logic DATA_STROBE_LINE_N_OE,
  input wire logic AUTO_FEED_LINE_N_OE,
  input wire logic SELECT_IN_LINE_N_OE,
  input wire logic PRINTER_INIT_N_O,
  input wire logic [5:0] MODE_SEL,
  input wire logic COMPAT_QUAL
);
  timeunit 1ns;
  timeprecision 100ps;
  logic en_r, dyn, ecr_wr;
  logic [7:0] cfg_r, low_cnt_r;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  // Shadows of enable and configuration
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      en_r <= 1'b0;
      cfg_r <= 8'hf0;
    end else begin
      if (FUNC_ENABLE_ONE_WR) en_r <= CFG_WDATA[4];
      if (CFG_WR && CFG_INDEX == 8'hf0) cfg_r <= CFG_WDATA;
    end
  end
  // Strobe low time counted here, since a repetition cannot reach 125
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) low_cnt_r <= 8'h00;
    else low_cnt_r <= DATA_STROBE_LINE_N_O ? 8'h00 : low_cnt_r + 8'h01;
  end
  assign dyn = cfg_r[4] && cfg_r[7:6] == 2'b11;
  assign ecr_wr = en_r && dyn && BUS_WR && BUS_ADDR == 11'h402;
  // Mode for codes 0-3 of the static (d=0) or dynamic (d=1) table
  function automatic logic [5:0] mode_of(input logic d, input logic [1:0] c);
    case (c)
      2'd0: return ppm_pkg::MODE_SPP_COMPAT;
      2'd1: return ppm_pkg::MODE_SPP_EXT;
      2'd2: return d ? ppm_pkg::MODE_FIFO_OUT : ppm_pkg::MODE_EPP17;
      default: return d ? ppm_pkg::MODE_ECP : ppm_pkg::MODE_EPP19;
    endcase
  endfunction
  a_reset_mode_ecp: assert property (disable iff (1'b0) !ARST_N |-> MODE_SEL == ppm_pkg::MODE_ECP)
    else $error("mode not ECP in reset");
  a_reset_pins_float: assert property (disable iff (1'b0)
    !ARST_N |-> !(DATA_STROBE_LINE_N_OE || AUTO_FEED_LINE_N_OE || SELECT_IN_LINE_N_OE || PRINTER_INIT_N_O)
    && IRQ_OE == 16'h0000) else $error("pins not floated in reset");
  a_mode_onehot: assert property ($onehot(MODE_SEL)) else $error("mode select not one-hot");
  a_static_decode: assert property (CFG_WR && CFG_INDEX == 8'hf0 && !CFG_WDATA[7]
    |-> ##2 MODE_SEL == mode_of(1'b0, $past(CFG_WDATA[6:5], 2))) else $error("static mode wrong");
  a_dynamic_decode: assert property (ecr_wr && !BUS_WDATA[7]
    |-> ##2 MODE_SEL == mode_of(1'b1, $past(BUS_WDATA[6:5], 2))) else $error("dynamic mode wrong");
  a_unassigned_keep: assert property (ecr_wr && BUS_WDATA[7:5] > 3'd4 |=> $stable(MODE_SEL) [*2])
    else $error("unassigned code changed mode");
  a_disabled_silent: assert property (!en_r && !FUNC_ENABLE_ONE_WR |=> BUS_RDATA == 8'h00)
    else $error("disabled port answered");
  a_compat_qual: assert property (MODE_SEL == ppm_pkg::MODE_ECP [*3] |-> !COMPAT_QUAL)
    else $error("qualifier set in ECP");
  a_route_legal: assert property ($onehot0(DRQ) && $onehot0(IRQ_OE) && !IRQ_OE[0] && !IRQ_OE[2]
    && !IRQ_OE[13]) else $error("illegal interrupt or DMA routing");
  a_strobe_width: assert property ($rose(DATA_STROBE_LINE_N_O) && MODE_SEL == ppm_pkg::MODE_FIFO_OUT
    |-> low_cnt_r == 8'd125) else $error("strobe width wrong");
  c_fifo_strobe: cover property ($rose(DATA_STROBE_LINE_N_O) && MODE_SEL == ppm_pkg::MODE_FIFO_OUT);
  c_epp19: cover property (MODE_SEL == ppm_pkg::MODE_EPP19);
  c_qual: cover property (COMPAT_QUAL);
endmodule
`default_nettype wire

// ---- ppm_printer.sv ----
// Printer model: busy, acknowledge and reverse data
`default_nettype none
module ppm_printer (
  input wire logic clk,
  input wire logic stb_n,
  input wire logic [7:0] pd_o,
  input wire logic pd_oe,
  input wire logic [7:0] rev_data,
  input wire logic [7:0] dly,
  output logic ack_n,
  output logic busy,
  output logic [7:0] pd_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt = 8'h00;
  initial ack_n = 1'b1;
  initial busy = 1'b0;
  // Busy from strobe until the acknowledge pulse ends
  always @(posedge clk) begin
    if (!stb_n) begin
      busy <= 1'b1;
      cnt <= 8'h00;
    end else if (busy) begin
      cnt <= cnt + 8'h01;
      if (cnt == dly) ack_n <= 1'b0;
      if (cnt == dly + 8'h04) begin
        ack_n <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
  // Printer drives the lines whenever the port has released them
  assign pd_i = pd_oe ? pd_o : rev_data;
endmodule
`default_nettype wire

// ---- ppm_tb.sv ----
// Self-checking bench of the parallel port mode block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLOCK = 1'b0, ARST_N = 1'b1, BUS_WR = 1'b0, BUS_RD = 1'b0, CFG_WR = 1'b0, FUNC_ENABLE_ONE_WR = 1'b0;
  logic [10:0] BUS_ADDR = 11'h000;
  logic [7:0] BUS_WDATA = 8'h00, CFG_INDEX = 8'h00, CFG_WDATA = 8'h00, rev_data = 8'h00, dly = 8'h02;
  logic [2:0] DACK_N = 3'h7;
  logic PAPER_END_I = 1'b0, SELECT_I = 1'b1, ERROR_N_I = 1'b1, stb_prev = 1'b1;
  logic [7:0] BUS_RDATA, CFG_RDATA, PD_I, PD_O, v;
  logic [15:0] IRQ_O, IRQ_OE;
  logic [5:0] MODE_SEL;
  logic [2:0] DRQ;
  logic PD_OE, DATA_STROBE_LINE_N_O, DATA_STROBE_LINE_N_OE, AUTO_FEED_LINE_N_O, AUTO_FEED_LINE_N_OE;
  logic SELECT_IN_LINE_N_O, SELECT_IN_LINE_N_OE, PRINTER_INIT_N_O, ACK_N_I, BUSY_I, COMPAT_QUAL;
  int miscompares = 0, total_checks = 0, i;
  int seed = 32'h0603_e0c7;
  logic [7:0] exp_q[$];
  logic [5:0] stat_tab [4] = '{ppm_pkg::MODE_SPP_COMPAT, ppm_pkg::MODE_SPP_EXT, ppm_pkg::MODE_EPP17,
    ppm_pkg::MODE_EPP19};
  logic [5:0] dyn_tab [4] = '{ppm_pkg::MODE_SPP_COMPAT, ppm_pkg::MODE_SPP_EXT, ppm_pkg::MODE_FIFO_OUT,
    ppm_pkg::MODE_ECP};
  always #2 CLOCK = ~CLOCK;
  ppm_port dut (.*);
  ppm_printer printer (.clk(CLOCK), .stb_n(DATA_STROBE_LINE_N_OE ? DATA_STROBE_LINE_N_O : 1'b1), .pd_o(PD_O),
    .pd_oe(PD_OE), .rev_data(rev_data), .dly(dly), .ack_n(ACK_N_I), .busy(BUSY_I), .pd_i(PD_I));
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bus cycles: strobe held for one sampling edge
  task automatic bus_wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    BUS_ADDR <= a;
    BUS_WDATA <= d;
    BUS_WR <= 1'b1;
    @(posedge CLOCK);
    BUS_WR <= 1'b0;
    repeat (2) @(posedge CLOCK);
    #1;
  endtask
  task automatic bus_rd(input logic [10:0] a, output logic [7:0] d);
    @(posedge CLOCK);
    BUS_ADDR <= a;
    BUS_RD <= 1'b1;
    @(posedge CLOCK);
    BUS_RD <= 1'b0;
    #1 d = BUS_RDATA;
  endtask
  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d, input logic fe);
    @(posedge CLOCK);
    CFG_INDEX <= idx;
    CFG_WDATA <= d;
    CFG_WR <= !fe;
    FUNC_ENABLE_ONE_WR <= fe;
    @(posedge CLOCK);
    CFG_WR <= 1'b0;
    FUNC_ENABLE_ONE_WR <= 1'b0;
    repeat (2) @(posedge CLOCK);
    #1;
  endtask
  // A falling strobe carries the oldest queued byte
  always @(negedge CLOCK) begin
    if (stb_prev && !DATA_STROBE_LINE_N_O && MODE_SEL === ppm_pkg::MODE_FIFO_OUT && exp_q.size() > 0)
      chk("fifo byte", PD_O, exp_q.pop_front());
    stb_prev <= DATA_STROBE_LINE_N_O;
  end
  // Hang guard
  initial begin
    repeat (40000) @(posedge CLOCK);
    miscompares++;
    conclude();
  end
  initial begin
    ARST_N <= 1'b0;
    repeat (10) @(posedge CLOCK);
    #1;
    chk("reset mode", MODE_SEL, ppm_pkg::MODE_ECP);
    chk("reset pins", {DATA_STROBE_LINE_N_OE, AUTO_FEED_LINE_N_OE, SELECT_IN_LINE_N_OE, PRINTER_INIT_N_O}, 0);
    chk("reset irq", IRQ_OE, 16'h0000);
    repeat (10) @(posedge CLOCK);
    ARST_N <= 1'b1;
    bus_wr(11'h402, 8'h21);
    bus_rd(11'h402, v);
    chk("disabled read", v, 8'h00);
    chk("disabled mode", MODE_SEL, ppm_pkg::MODE_ECP);
    cfg_wr(8'h00, 8'h10, 1'b1);
    bus_wr(11'h002, 8'h04);
    for (i = 0; i < 4; i++) begin
      cfg_wr(8'hf0, {i[2:0], 5'h00}, 1'b0);
      chk("static mode", MODE_SEL, stat_tab[i]);
    end
    for (i = 0; i < 2; i++) begin
      cfg_wr(8'hf0, {2'b11, i[0], 5'h10}, 1'b0);
      chk("dynamic start", MODE_SEL, ppm_pkg::MODE_ECP);
    end
    for (i = 0; i < 4; i++) begin
      bus_wr(11'h402, {i[2:0], 5'h01});
      chk("dynamic mode", MODE_SEL, dyn_tab[i]);
    end
    for (i = 0; i < 2; i++) begin
      bus_wr(11'h403, 8'h02);
      bus_wr(11'h404, {3'b100, i[0], 4'h0});
      bus_rd(11'h404, v);
      chk("secondary readback", v, {3'b100, i[0], 4'h0});
      bus_wr(11'h402, 8'h81);
      chk("epp revision", MODE_SEL, i ? ppm_pkg::MODE_EPP19 : ppm_pkg::MODE_EPP17);
      chk("qualifier", COMPAT_QUAL, 1'b1);
    end
    bus_wr(11'h402, 8'ha1);
    chk("unassigned code", MODE_SEL, ppm_pkg::MODE_EPP19);
    bus_wr(11'h402, 8'h61);
    chk("ecp qualifier", COMPAT_QUAL, 1'b0);
    bus_wr(11'h402, 8'h01);
    v = 8'($random(seed));
    bus_wr(11'h000, v);
    chk("compat output", {PD_OE, PD_O}, {1'b1, v});
    bus_wr(11'h402, 8'h21);
    @(posedge CLOCK);
    rev_data <= 8'($random(seed));
    bus_wr(11'h002, 8'h24);
    bus_rd(11'h000, v);
    chk("extended read", {PD_OE, v}, {1'b0, rev_data});
    bus_wr(11'h002, 8'h04);
    bus_wr(11'h402, 8'h41);
    @(posedge CLOCK);
    dly <= 8'h30;
    for (i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      exp_q.push_back(v);
      bus_wr(11'h400, v);
    end
    for (i = 0; i < 5000 && exp_q.size() > 0; i++) @(posedge CLOCK);
    chk("fifo drained", exp_q.size(), 0);
    repeat (200) @(posedge CLOCK);
    cfg_wr(8'h70, 8'h05, 1'b0);
    cfg_wr(8'h70, 8'h02, 1'b0);
    chk("irq select", CFG_RDATA[3:0], 4'h5);
    cfg_wr(8'h74, 8'h01, 1'b0);
    cfg_wr(8'h74, 8'h03, 1'b0);
    chk("dma select", CFG_RDATA[1:0], 2'h1);
    conclude();
  end
endmodule
bind ppm_port ppm_port_chk chk (.*);
`default_nettype wire
